// ---- rtl/pp_address_and_transfer_request_regs.sv ----
// Purpose: Local and global address registers plus the transfer handshake register
// Assumes: One clock, synchronous active-high reset, core accesses by register code
// Notes:   Local accesses are routed to a port here; the memory system itself lives outside
//
// Chosen here: the placing of the registers and the plain strobed port.

`timescale 1ns/100ps

// Operation
// - Reset leaves reserved bits and address registers undefined
// - Five local address registers, codes 0000 000-100
// - Local address registers readable as ALU operands
// - No global transfer: local access uses global port
// - Global busy: try local port, stall, retry
// - Five global address registers, codes 0001 000-100
// - Global address registers readable as ALU operands
// - Handshake register at code 0111 110
// - Reset clears priority, suspend, queued, request
// - Priority bit captured when request submitted
// - Suspend bit holds the queued request
// - Queued bit follows request after one slot; here two cycles after
// - Request write only if suspend clear/clearing
// - Read-only two-bit processor index
// - Bit 2 above index reads zero
// - Low three code bits select register, companion
module pp_address_and_transfer_request_regs
  import xfer_regs_pkg::*;
#(
  parameter logic [1:0] PROC_INDEX = 2'h0
) (
  input  wire logic               SYS_CLK,
  input  wire logic               RESET,
  input  wire logic [CODE_W-1:0]  REG_CODE,
  input  wire logic [DATA_W-1:0]  REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output logic      [DATA_W-1:0]  REG_RDATA,
  input  wire logic [CODE_W-1:0]  ALU_SRC_CODE,
  output logic      [DATA_W-1:0]  ALU_SRC_DATA,
  output logic      [2:0]         COMPANION_IDX,
  input  wire logic               LOCAL_ACC,
  input  wire logic [2:0]         LOCAL_ACC_IDX,
  input  wire logic               GLOBAL_XFER_BUSY,
  input  wire logic               ADDR_IS_LOCAL_RAM,
  output logic                    LOCAL_PORT_VALID,
  output logic                    GLOBAL_PORT_VALID,
  output logic      [DATA_W-1:0]  ACC_ADDR,
  output logic                    PIPE_STALL,
  output logic                    XFER_REQ_VALID,
  output logic                    XFER_HIGH_PRIO,
  output logic                    XFER_SUSPEND,
  input  wire logic               XFER_ACCEPT,
  input  wire logic               XFER_DONE
);

  // All block state in one record
  typedef struct packed {
    logic [ADDR_REGS-1:0][DATA_W-1:0] local_addr;
    logic [ADDR_REGS-1:0][DATA_W-1:0] global_addr;
    logic                             prio;
    logic                             susp;
    logic                             queued;
    logic                             req;
    logic                             req_seen;
    xfer_state_e                      xs;
    logic [DATA_W-1:0]                rdata;
    logic [DATA_W-1:0]                alu_data;
    logic [2:0]                       comp_idx;
    logic                             stalled;
    logic [2:0]                       stall_idx;
    mem_access_s                      lport;
    mem_access_s                      gport;
    xfer_req_s                        xreq;
    logic [DATA_W-1:0]                acc_addr;
  } state_s;

  state_s st_q;
  state_s st_d;

  // Read decode shared by the register read port and the ALU source port
  function automatic logic [DATA_W-1:0] read_code(input state_s s, input logic [6:0] code);
    logic [3:0] bank;
    logic [2:0] idx;
    bank = code_bank(code);
    idx  = code_index(code);
    read_code = RST_WORD;
    if (bank == BANK_LOCAL && idx <= IDX_LAST_ADDR) begin
      read_code = s.local_addr[idx];
    end else if (bank == BANK_GLOBAL && idx <= IDX_LAST_ADDR) begin
      read_code = s.global_addr[idx];
    end else if (bank == BANK_SPECIAL && idx == IDX_HANDSHAKE) begin
      read_code[BIT_PRIO]   = s.prio;
      read_code[BIT_SUSP]   = s.susp;
      read_code[BIT_QUEUED] = s.queued;
      read_code[BIT_REQ]    = s.req;
      read_code[1:0]        = PROC_INDEX;
      read_code[BIT_IDX_HI] = 1'b0;
    end
  endfunction

  // Next-state logic
  always_comb begin
    logic [3:0] wbank;
    logic [2:0] widx;
    logic       hs_wr;
    logic       susp_next;
    logic       lacc;
    logic [2:0] lidx;
    st_d  = st_q;
    wbank = code_bank(REG_CODE);
    widx  = code_index(REG_CODE);
    hs_wr = REG_WR && wbank == BANK_SPECIAL && widx == IDX_HANDSHAKE;
    susp_next = hs_wr ? REG_WDATA[BIT_SUSP] : st_q.susp;
    lacc  = 1'b0;
    lidx  = LOCAL_ACC_IDX;

    // Address register writes
    if (REG_WR && wbank == BANK_LOCAL && widx <= IDX_LAST_ADDR) begin
      st_d.local_addr[widx] = REG_WDATA;
    end
    if (REG_WR && wbank == BANK_GLOBAL && widx <= IDX_LAST_ADDR) begin
      st_d.global_addr[widx] = REG_WDATA;
    end

    // Handshake writes; the request bit is guarded by the suspend bit
    if (hs_wr) begin
      st_d.prio = REG_WDATA[BIT_PRIO];
      st_d.susp = REG_WDATA[BIT_SUSP];
      if (!susp_next) begin
        st_d.req = REG_WDATA[BIT_REQ];
      end
    end

    // Queued appears two cycles after the request is set
    st_d.req_seen = st_q.req && !XFER_DONE;
    if (st_q.req && st_q.req_seen && !XFER_DONE) begin
      st_d.queued = 1'b1;
    end

    // Transfer request sequencing toward the controller
    case (st_q.xs)
      XS_IDLE: begin
        if (st_q.req && !XFER_DONE) begin
          st_d.xs = XS_PENDING;
        end
      end
      XS_PENDING: begin
        if (XFER_ACCEPT) begin
          st_d.xs = XS_ACTIVE;
        end
      end
      XS_ACTIVE: begin
        st_d.xs = XS_ACTIVE;
      end
      default: begin
        st_d.xs = XS_IDLE;
      end
    endcase
    if (XFER_DONE) begin
      st_d.req      = 1'b0;
      st_d.queued   = 1'b0;
      st_d.req_seen = 1'b0;
      st_d.xs       = XS_IDLE;
    end
    // Priority is sampled at submission, so later writes do not change it
    st_d.xreq.valid   = st_d.xs == XS_PENDING || st_d.xs == XS_ACTIVE;
    st_d.xreq.suspend = st_d.susp;
    if (st_q.xs == XS_IDLE && st_d.xs == XS_PENDING) begin
      st_d.xreq.high_prio = st_q.prio;
    end

    // Local-register memory access routing
    st_d.lport = '0;
    st_d.gport = '0;
    if (st_q.stalled) begin
      lacc = !GLOBAL_XFER_BUSY;
      lidx = st_q.stall_idx;
      if (lacc) begin
        st_d.stalled    = 1'b0;
        st_d.gport      = '{valid: 1'b1, on_global: 1'b1, addr: st_q.local_addr[lidx]};
      end
    end else if (LOCAL_ACC && LOCAL_ACC_IDX <= IDX_LAST_ADDR) begin
      if (!GLOBAL_XFER_BUSY) begin
        st_d.gport = '{valid: 1'b1, on_global: 1'b1, addr: st_q.local_addr[lidx]};
      end else if (ADDR_IS_LOCAL_RAM) begin
        st_d.lport = '{valid: 1'b1, on_global: 1'b0, addr: st_q.local_addr[lidx]};
      end else begin
        st_d.stalled   = 1'b1;
        st_d.stall_idx = lidx;
      end
    end
    // Address is registered here so the port output needs no mux after the flop
    st_d.acc_addr = st_d.gport.valid ? st_d.gport.addr : st_d.lport.addr;

    // Read ports
    st_d.rdata    = REG_RD ? read_code(st_q, REG_CODE) : RST_WORD;
    st_d.alu_data = read_code(st_q, ALU_SRC_CODE);
    st_d.comp_idx = code_index(ALU_SRC_CODE);

    // Reset clears control state, read data and access address; address registers keep no defined value
    if (RESET) begin
      st_d.prio     = RST_HS_BIT;
      st_d.susp     = RST_HS_BIT;
      st_d.queued   = RST_HS_BIT;
      st_d.req      = RST_HS_BIT;
      st_d.req_seen = 1'b0;
      st_d.xs       = XS_IDLE;
      st_d.rdata    = RST_WORD;
      st_d.stalled  = 1'b0;
      st_d.lport    = '0;
      st_d.gport    = '0;
      st_d.xreq     = '0;
      st_d.alu_data = RST_WORD;
      st_d.comp_idx = 3'h0;
      st_d.stall_idx = 3'h0;
      st_d.acc_addr  = RST_WORD;
      st_d.local_addr  = st_q.local_addr;
      st_d.global_addr = st_q.global_addr;
    end
  end

  // State register
  always_ff @(posedge SYS_CLK) begin
    st_q <= st_d;
  end

  // Outputs straight from the state record
  assign REG_RDATA         = st_q.rdata;
  assign ALU_SRC_DATA      = st_q.alu_data;
  assign COMPANION_IDX     = st_q.comp_idx;
  assign LOCAL_PORT_VALID  = st_q.lport.valid;
  assign GLOBAL_PORT_VALID = st_q.gport.valid;
  assign ACC_ADDR          = st_q.acc_addr;
  assign PIPE_STALL        = st_q.stalled;
  assign XFER_REQ_VALID    = st_q.xreq.valid;
  assign XFER_HIGH_PRIO    = st_q.xreq.high_prio;
  assign XFER_SUSPEND      = st_q.xreq.suspend;

endmodule

// ---- rtl/xfer_regs_pkg.sv ----
// Purpose: Shared constants and carriers for the address and transfer handshake registers
// Assumes: Seven-bit register codes, bank in the upper four bits, index in the lower three
// Notes:   Handshake bit positions are chosen here; the index field sits in bits 1:0

package xfer_regs_pkg;

  localparam int unsigned DATA_W       = 32;
  localparam int unsigned CODE_W       = 7;

  // Register banks, upper four bits of a register code; indices within a bank, lower three bits
  localparam logic [3:0]  BANK_LOCAL   = 4'h0;
  localparam logic [3:0]  BANK_GLOBAL  = 4'h1;
  localparam logic [3:0]  BANK_SPECIAL = 4'h7;
  localparam logic [2:0]  IDX_HANDSHAKE = 3'h6;
  localparam logic [2:0]  IDX_LAST_ADDR = 3'h4;
  localparam int unsigned ADDR_REGS    = 5;

  // Handshake register field positions
  localparam int unsigned BIT_PRIO     = 31;
  localparam int unsigned BIT_SUSP     = 30;
  localparam int unsigned BIT_QUEUED   = 29;
  localparam int unsigned BIT_REQ      = 28;
  localparam int unsigned BIT_IDX_HI   = 2;

  // Reset values of the handshake bits and of the registered data words
  localparam logic        RST_HS_BIT   = 1'b0;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;

  // Address register ports
  localparam int unsigned ADDR_PORT_W  = 3;

  typedef enum logic [1:0] {
    XS_IDLE,
    XS_PENDING,
    XS_ACTIVE
  } xfer_state_e;

  // Request carried to the transfer controller
  typedef struct packed {
    logic valid;
    logic high_prio;
    logic suspend;
  } xfer_req_s;

  // Memory access issued through an address register
  typedef struct packed {
    logic        valid;
    logic        on_global;
    logic [31:0] addr;
  } mem_access_s;

  // Bank decode of a register code
  function automatic logic [3:0] code_bank(input logic [6:0] code);
    return code[6:3];
  endfunction

  // Index within bank, also the companion data register number
  function automatic logic [2:0] code_index(input logic [6:0] code);
    return code[2:0];
  endfunction

endpackage

// ---- verification/pp_regs_chk.sv ----
// Purpose: Timing checks on the register, handshake and routing ports
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only top-level ports; attached by bind below
`timescale 1ns/100ps
module pp_regs_chk
  import xfer_regs_pkg::*;
#(
  parameter logic [1:0] PROC_INDEX = 2'h0
) (
  input wire logic              SYS_CLK,
  input wire logic              RESET,
  input wire logic [CODE_W-1:0] REG_CODE,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  input wire logic [CODE_W-1:0] ALU_SRC_CODE,
  input wire logic [2:0]        COMPANION_IDX,
  input wire logic              LOCAL_ACC,
  input wire logic              GLOBAL_XFER_BUSY,
  input wire logic              ADDR_IS_LOCAL_RAM,
  input wire logic              GLOBAL_PORT_VALID,
  input wire logic              PIPE_STALL,
  input wire logic              XFER_REQ_VALID,
  input wire logic              XFER_HIGH_PRIO,
  input wire logic              XFER_SUSPEND,
  input wire logic              XFER_DONE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  wire hs_wr = REG_WR && REG_CODE == 7'h3E;
  // Accepted request write with no completion in the way
  sequence s_req;
    hs_wr && REG_WDATA[28] && !REG_WDATA[30] && !XFER_DONE ##1 !XFER_DONE;
  endsequence
  chk_req_submit: assert property (s_req |=> XFER_REQ_VALID)
    else $error("request not raised");
  chk_prio_take: assert property (s_req |=> XFER_HIGH_PRIO == $past(REG_WDATA[31], 2))
    else $error("priority not latched");
  chk_req_refused: assert property (hs_wr && REG_WDATA[30] && !XFER_REQ_VALID
    && !$past(REG_WR) |=> ##1 !XFER_REQ_VALID) else $error("suspended request taken");
  chk_susp_copy: assert property (hs_wr |=> XFER_SUSPEND == $past(REG_WDATA[30]))
    else $error("suspend not followed");
  chk_done_clear: assert property (XFER_DONE |=> !XFER_REQ_VALID)
    else $error("completion ignored");
  chk_index_read: assert property (REG_RD && REG_CODE == 7'h3E
    |=> REG_RDATA[2:0] == {1'b0, PROC_INDEX}) else $error("index field wrong");
  chk_comp_index: assert property (REG_RD |=> COMPANION_IDX == $past(ALU_SRC_CODE[2:0]))
    else $error("companion index wrong");
  chk_no_stall: assert property (LOCAL_ACC && !GLOBAL_XFER_BUSY && !PIPE_STALL
    |=> GLOBAL_PORT_VALID && !PIPE_STALL) else $error("free global port not used");
  chk_stall_enter: assert property (LOCAL_ACC && GLOBAL_XFER_BUSY && !ADDR_IS_LOCAL_RAM
    && !PIPE_STALL |=> PIPE_STALL && !GLOBAL_PORT_VALID) else $error("no stall");
  chk_stall_release: assert property (PIPE_STALL && !GLOBAL_XFER_BUSY
    |=> !PIPE_STALL && GLOBAL_PORT_VALID) else $error("no retry on global port");
endmodule
bind pp_address_and_transfer_request_regs pp_regs_chk #(.PROC_INDEX(PROC_INDEX)) u_pp_regs_chk (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_CODE(REG_CODE), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ALU_SRC_CODE(ALU_SRC_CODE),
  .COMPANION_IDX(COMPANION_IDX), .LOCAL_ACC(LOCAL_ACC), .GLOBAL_XFER_BUSY(GLOBAL_XFER_BUSY),
  .ADDR_IS_LOCAL_RAM(ADDR_IS_LOCAL_RAM), .GLOBAL_PORT_VALID(GLOBAL_PORT_VALID),
  .PIPE_STALL(PIPE_STALL), .XFER_REQ_VALID(XFER_REQ_VALID), .XFER_HIGH_PRIO(XFER_HIGH_PRIO),
  .XFER_SUSPEND(XFER_SUSPEND), .XFER_DONE(XFER_DONE));

// ---- verification/xfer_ctrl_model.sv ----
// Purpose: Behavioural transfer controller on the far side of the handshake
// Assumes: Same clock as the register block
// Notes:   lat sets the wait before accept and again before completion
`timescale 1ns/100ps
module xfer_ctrl_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic       susp,
  input  wire logic [3:0] lat,
  output logic            accept,
  output logic            done
);
  logic [4:0] cnt_q;
  logic       act_q;
  // Never starts a suspended request, so a held suspend really stalls it
  always_ff @(posedge clk) begin
    accept <= 1'b0;
    done <= 1'b0;
    if (rst || !req || done) begin
      cnt_q <= 5'h00;
      act_q <= 1'b0;
    end else if (susp && !act_q) begin
      cnt_q <= 5'h00;
    end else if (cnt_q == {1'b0, lat}) begin
      cnt_q <= 5'h00;
      accept <= !act_q;
      done <= act_q;
      act_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the address and handshake registers
// Assumes: Controller model answers the transfer handshake
// Notes:   Index set to 2 so the index field is not all zero
`timescale 1ns/100ps
module testbench import xfer_regs_pkg::*;;
  logic              SYS_CLK = 1'b0, RESET = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
  logic              LOCAL_ACC = 1'b0, GLOBAL_XFER_BUSY = 1'b0, ADDR_IS_LOCAL_RAM = 1'b0;
  logic [CODE_W-1:0] REG_CODE = 7'h00, ALU_SRC_CODE = 7'h00;
  logic [2:0]        LOCAL_ACC_IDX = 3'h0, COMPANION_IDX;
  logic [DATA_W-1:0] REG_WDATA = 32'h0, REG_RDATA, ALU_SRC_DATA, ACC_ADDR;
  logic              LOCAL_PORT_VALID, GLOBAL_PORT_VALID, PIPE_STALL, XFER_REQ_VALID;
  logic              XFER_HIGH_PRIO, XFER_SUSPEND, XFER_ACCEPT, XFER_DONE;
  logic [3:0]        lat = 4'h3;
  int                fail_count = 0, total_checks = 0;
  logic [6:0]        codes [12] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h08,
                                    7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h05, 7'h0D};
  pp_address_and_transfer_request_regs #(.PROC_INDEX(2'h2)) u_pp_address_and_transfer_request_regs (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_CODE(REG_CODE), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ALU_SRC_CODE(ALU_SRC_CODE),
    .ALU_SRC_DATA(ALU_SRC_DATA), .COMPANION_IDX(COMPANION_IDX), .LOCAL_ACC(LOCAL_ACC),
    .LOCAL_ACC_IDX(LOCAL_ACC_IDX), .GLOBAL_XFER_BUSY(GLOBAL_XFER_BUSY),
    .ADDR_IS_LOCAL_RAM(ADDR_IS_LOCAL_RAM), .LOCAL_PORT_VALID(LOCAL_PORT_VALID),
    .GLOBAL_PORT_VALID(GLOBAL_PORT_VALID), .ACC_ADDR(ACC_ADDR), .PIPE_STALL(PIPE_STALL),
    .XFER_REQ_VALID(XFER_REQ_VALID), .XFER_HIGH_PRIO(XFER_HIGH_PRIO),
    .XFER_SUSPEND(XFER_SUSPEND), .XFER_ACCEPT(XFER_ACCEPT), .XFER_DONE(XFER_DONE));
  xfer_ctrl_model u_xfer_ctrl_model (.clk(SYS_CLK), .rst(RESET), .req(XFER_REQ_VALID),
    .susp(XFER_SUSPEND), .lat(lat), .accept(XFER_ACCEPT), .done(XFER_DONE));
  always #10 SYS_CLK = ~SYS_CLK;
  function automatic logic [31:0] pat(input logic [6:0] c);
    return 32'h5A5A_0000 | {25'h0, c};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Strobe is held across back-to-back writes; the next access drops it
  task automatic wr(input logic [6:0] c, input logic [31:0] d);
    REG_CODE <= c;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
  endtask
  task automatic idle(input int n);
    REG_WR <= 1'b0;
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic rd_chk(input logic [6:0] c, input logic [31:0] e);
    REG_WR <= 1'b0;
    REG_CODE <= c;
    ALU_SRC_CODE <= c;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    // Look mid-cycle, while the read data stand
    @(negedge SYS_CLK);
    chk(REG_RDATA, e);
    @(posedge SYS_CLK);
  endtask
  task automatic wait_idle;
    REG_WR <= 1'b0;
    for (int n = 0; n < 60 && XFER_REQ_VALID !== 1'b0; n++) @(posedge SYS_CLK);
    chk({31'h0, XFER_REQ_VALID}, 32'h0);
  endtask
  task automatic acc(input logic [2:0] i, input logic b, input logic l);
    @(posedge SYS_CLK);
    LOCAL_ACC <= 1'b1;
    LOCAL_ACC_IDX <= i;
    GLOBAL_XFER_BUSY <= b;
    ADDR_IS_LOCAL_RAM <= l;
    @(posedge SYS_CLK);
    LOCAL_ACC <= 1'b0;
    @(negedge SYS_CLK);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence: table rows first, then handshake and routing cases
  initial begin
    repeat (6) @(posedge SYS_CLK);
    RESET <= 1'b0;
    @(posedge SYS_CLK);
    rd_chk(7'h3E, 32'h0000_0002);
    foreach (codes[i]) wr(codes[i], pat(codes[i]));
    foreach (codes[i]) begin
      rd_chk(codes[i], i < 10 ? pat(codes[i]) : 32'h0);
      if (i < 10) chk(ALU_SRC_DATA, pat(codes[i]));
    end
    $display("Test register rows done");
    wr(7'h3E, 32'h9000_0000);
    rd_chk(7'h3E, 32'h9000_0002);
    rd_chk(7'h3E, 32'hB000_0002);
    wait_idle;
    rd_chk(7'h3E, 32'h8000_0002);
    wr(7'h3E, 32'h5000_0000);
    rd_chk(7'h3E, 32'h4000_0002);
    wr(7'h3E, 32'h1000_0000);
    rd_chk(7'h3E, 32'h1000_0002);
    wait_idle;
    lat <= 4'h0;
    wr(7'h3E, 32'h1000_0000);
    wr(7'h3E, 32'h5000_0000);
    idle(8);
    chk({31'h0, XFER_REQ_VALID}, 32'h1);
    wr(7'h3E, 32'h1000_0000);
    wait_idle;
    $display("Test handshake done");
    for (int i = 0; i < 5; i++) begin
      acc(i[2:0], 1'b0, 1'b0);
      chk(ACC_ADDR, pat({4'h0, i[2:0]}));
    end
    acc(3'h1, 1'b1, 1'b1);
    chk({29'h0, GLOBAL_PORT_VALID, LOCAL_PORT_VALID, PIPE_STALL}, 32'h2);
    acc(3'h2, 1'b1, 1'b0);
    idle(3);
    chk({29'h0, GLOBAL_PORT_VALID, LOCAL_PORT_VALID, PIPE_STALL}, 32'h1);
    GLOBAL_XFER_BUSY <= 1'b0;
    idle(1);
    @(negedge SYS_CLK);
    chk({29'h0, GLOBAL_PORT_VALID, LOCAL_PORT_VALID, PIPE_STALL}, 32'h4);
    $display("Test routing done");
    tally_and_finish;
  end
  // Watchdog sized well above the roughly 110 cycles the tests take
  initial begin
    repeat (2000) @(posedge SYS_CLK);
    fail_count++;
    tally_and_finish;
  end
endmodule
